// >>> core/isd_space_decoder.sv
`timescale 1ns/10ps
// What this block does
// - base code zero disables the whole region
// - codes 1..3 place base at 1G/2G/3G
// - address bits 31:30 compared to base code
// - bits 29:24 must be zero to hit
// - bit 23 splits control and graphics memory
// - bits 22:16 ignored in control space
// - bit 15 splits scratch/pci from registers
// - bus interface unit at 8000h, 100h long
// - graphics pipeline at 8100h, 200h long
// - display controller at 8300h, 100h long
// - memory controller at 8400h, 100h long
// - power management at 8500h through 8FFFh
// - undefined register addresses complete without error
// - graphics memory window at base plus 800000h
// - config register 8 bits, reset zero
// - scratch size codes give 0/2/3/4 KB
// - config register reached at i/o index B8h
module isd_space_decoder
  import isd_pkg::*;
(
  input  wire logic       i_clk,        // core clock, 250 mhz
  input  wire logic       i_sys_rst,    // sync reset, high
  input  wire logic       i_ce,         // clock enable
  input  wire logic       i_cfg_wr,     // config write strobe
  input  wire logic       i_cfg_rd,     // config read strobe
  input  wire logic [7:0] i_cfg_index,  // config index
  input  wire logic [7:0] i_cfg_wdata,  // config write data
  output logic      [7:0] o_cfg_rdata,  // config read data
  input  isd_req_t        i_req,        // internal bus request
  output isd_sel_t        o_sel,        // one-hot unit select
  output logic            o_hit,        // request is in the region
  output logic            o_ack,        // request completes here
  output logic            o_ctrl_undef, // hole in register area
  output logic      [2:0] o_scratch_kb, // scratchpad size in kb
  output logic     [31:0] o_region_base_address // current base
);

  // ------------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------------
  isd_cfg_t cfg;          // live configuration
  logic     base_on;      // region enabled

  isd_cfg_reg u_cfg (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_ce         (i_ce),
    .i_cfg_wr     (i_cfg_wr),
    .i_cfg_rd     (i_cfg_rd),
    .i_cfg_index  (i_cfg_index),
    .i_cfg_wdata  (i_cfg_wdata),
    .o_cfg_rdata  (o_cfg_rdata),
    .o_cfg        (cfg),
    .o_scratch_kb (o_scratch_kb)
  );

  // ------------------------------------------------------------------
  // region base address, kept in a flop for software visibility
  // ------------------------------------------------------------------
  logic [31:0] base_addr_q; // registered base
  logic [31:0] base_addr_d; // base from current code

  // map the base code to its address
  always_comb begin
    unique case (cfg.region_base_sel)
      ISD_BASE_OFF: base_addr_d = ISD_BASE_ADDR_OFF;
      ISD_BASE_1G:  base_addr_d = ISD_BASE_ADDR_1G;
      ISD_BASE_2G:  base_addr_d = ISD_BASE_ADDR_2G;
      ISD_BASE_3G:  base_addr_d = ISD_BASE_ADDR_3G;
    endcase
  end

  // lags the config by one cycle; decode uses the code directly
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      base_addr_q <= 32'h0000_0000;
    end else if (i_ce) begin
      base_addr_q <= base_addr_d;
    end
  end

  assign o_region_base_address = base_addr_q;

  // ------------------------------------------------------------------
  // region decode
  // ------------------------------------------------------------------
  logic in_region;  // request falls in the 16 mb region
  logic ctrl_space; // lower 8 mb: control
  logic regs_space; // register half of control 64 kb
  logic [ISD_UNITS-1:0] unit_sel; // register unit hits
  logic unit_undef; // register hole

  // purely combinational so a select costs no cycle of latency
  always_comb begin
    base_on   = (cfg.region_base_sel != ISD_BASE_OFF);
    in_region = i_req.valid && base_on &&
                i_req.addr[31:30] == cfg.region_base_sel &&
                i_req.addr[29:24] == 6'h00;
    // bits 22:16 take no part, so any value aliases
    ctrl_space = in_region && !i_req.addr[ISD_ADDR_GFX_BIT];
    regs_space = ctrl_space && i_req.addr[ISD_ADDR_CTRL_BIT];
  end

  // register area subdivision among units
  isd_ctrl_decode u_ctrl (
    .i_en       (regs_space),
    .i_offset   (i_req.addr[15:0]),
    .o_unit_sel (unit_sel),
    .o_undef    (unit_undef)
  );

  // assemble the one-hot select
  always_comb begin
    o_sel             = '0;
    o_sel.gfx_mem     = in_region && i_req.addr[ISD_ADDR_GFX_BIT];
    o_sel.scratch_pci = ctrl_space && !i_req.addr[ISD_ADDR_CTRL_BIT];
    o_sel.bus_if      = unit_sel[0];
    o_sel.gpipe       = unit_sel[1];
    o_sel.display     = unit_sel[2];
    o_sel.memctl      = unit_sel[3];
    o_sel.power       = unit_sel[4];
  end

  // holes are acknowledged like any hit; no error path exists
  assign o_hit        = in_region;
  assign o_ack        = in_region;
  assign o_ctrl_undef = unit_undef;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic [31:0] a; // request address shorthand
  assign a = i_req.addr;

  AST_OFF_NO_HIT: assert property (
    cfg.region_base_sel == ISD_BASE_OFF |-> !o_hit && o_sel == '0)
    else $error("decode hit while region disabled");

  AST_BASE_ADDR: assert property (
    $stable(cfg) && cfg.region_base_sel == ISD_BASE_2G && i_ce
    |=> o_region_base_address == 32'h8000_0000)
    else $error("base address does not follow code");

  AST_BASE_BITS: assert property (
    o_hit |-> a[31:30] == cfg.region_base_sel && a[31:30] != 2'b00)
    else $error("hit with wrong upper address bits");

  AST_UPPER_ZERO: assert property (
    i_req.valid && base_on && a[31:30] == cfg.region_base_sel
    |-> o_hit == (a[29:24] == 6'h00))
    else $error("bits 29:24 not qualifying the hit");

  AST_GFX_SPLIT: assert property (
    o_hit |-> o_sel.gfx_mem == a[23] &&
              (a[23] || o_sel != '0 || o_ctrl_undef))
    else $error("bit 23 split wrong");

  AST_IGNORE_MID: assert property (
    o_hit && !a[23] && !a[15] |-> o_sel.scratch_pci)
    else $error("bits 22:16 affected control decode");

  AST_SCRATCH_SPLIT: assert property (
    o_sel.scratch_pci |-> o_hit && !a[23] && !a[15])
    else $error("scratch select outside its half");

  AST_BUS_IF: assert property (
    o_hit && !a[23] && a[15:8] == 8'h80 |-> o_sel.bus_if)
    else $error("bus interface window missed");

  AST_GPIPE: assert property (
    o_sel.gpipe |-> a[15:8] == 8'h81 || a[15:8] == 8'h82)
    else $error("pipeline select outside 8100h-82FFh");

  AST_DISPLAY: assert property (
    o_hit && !a[23] && a[15:8] == 8'h83 |-> o_sel.display)
    else $error("display window missed");

  AST_MEMCTL: assert property (
    o_sel.memctl |-> a[15:8] == 8'h84 && !a[23])
    else $error("memory controller select misplaced");

  AST_POWER: assert property (
    o_hit && !a[23] && a[15:12] == 4'h8 && a[11:8] >= 4'h5
    |-> o_sel.power)
    else $error("power window missed");

  AST_UNDEF_ACK: assert property (
    o_hit && !a[23] && a[15:12] != 4'h8 && a[15]
    |-> o_ctrl_undef && o_ack && o_sel == '0)
    else $error("register hole not completed quietly");

  AST_GFX_WINDOW: assert property (
    o_sel.gfx_mem |-> a[31:23] == {cfg.region_base_sel, 6'h00, 1'b1})
    else $error("graphics memory window misplaced");

  AST_CFG_RESET: assert property (
    $past(i_sys_rst) |-> cfg == '0 && o_region_base_address == '0)
    else $error("config not zero after reset");

  AST_SCR_SIZE: assert property (
    cfg.scratch_size_sel == 2'b10 |-> o_scratch_kb == 3'h3)
    else $error("scratch size code 10 not 3 kb");

  AST_CFG_WRITE: assert property (
    i_ce && i_cfg_wr && i_cfg_index == 8'hb8
    |=> {4'h0, cfg} == ($past(i_cfg_wdata) & 8'h0f))
    else $error("config write at index b8 lost");

  AST_CFG_READ: assert property (
    i_ce && i_cfg_rd && i_cfg_index == 8'hb8 && !i_cfg_wr
    |=> o_cfg_rdata[7:4] == 4'h0 && o_cfg_rdata[3:0] == cfg)
    else $error("config readback wrong");

  AST_ONE_HOT: assert property (
    $onehot0(o_sel) && (o_hit || o_sel == '0))
    else $error("select not one-hot");

  AST_FREEZE: assert property (
    !i_ce |=> $stable(cfg) && $stable(o_cfg_rdata))
    else $error("state moved with clock enable low");

  // base codes 00, 01 and 11 in turn (10 is checked above), so one wrong table entry cannot hide
  AST_BASE_OFF: assert property (
    cfg.region_base_sel == ISD_BASE_OFF && i_ce
    |=> o_region_base_address == 32'h0000_0000)
    else $error("base address not zero while disabled");

  AST_BASE_1G: assert property (
    cfg.region_base_sel == ISD_BASE_1G && i_ce
    |=> o_region_base_address == 32'h4000_0000)
    else $error("base address wrong for code 01");

  AST_BASE_3G: assert property (
    cfg.region_base_sel == ISD_BASE_3G && i_ce
    |=> o_region_base_address == 32'hc000_0000)
    else $error("base address wrong for code 11");

  // the flop copy of the base must freeze with everything else
  AST_BASE_FREEZE: assert property (
    !i_ce |=> $stable(o_region_base_address))
    else $error("base address moved with clock enable low");

  // remaining scratch size codes
  AST_SCR_SIZE_0: assert property (
    cfg.scratch_size_sel == 2'b00 |-> o_scratch_kb == 3'h0)
    else $error("scratch size code 00 not 0 kb");

  AST_SCR_SIZE_1: assert property (
    cfg.scratch_size_sel == 2'b01 |-> o_scratch_kb == 3'h2)
    else $error("scratch size code 01 not 2 kb");

  AST_SCR_SIZE_3: assert property (
    cfg.scratch_size_sel == 2'b11 |-> o_scratch_kb == 3'h4)
    else $error("scratch size code 11 not 4 kb");

  // completion never differs from the region hit
  AST_ACK_HIT: assert property (
    o_ack == o_hit)
    else $error("completion differs from region hit");

  AST_NO_VALID: assert property (
    !i_req.valid |-> !o_hit && o_sel == '0)
    else $error("decode without a valid request");

  AST_IN_REGION: assert property (
    o_hit |-> i_req.valid && a[29:24] == 6'h00)
    else $error("hit with nonzero bits 29:24");

  // reverse direction of the unit windows: hit inside, none outside
  AST_GPIPE_HIT: assert property (
    o_hit && !a[23] && (a[15:8] == 8'h81 || a[15:8] == 8'h82)
    |-> o_sel.gpipe)
    else $error("pipeline window missed");

  AST_BUS_IF_ONLY: assert property (
    o_sel.bus_if |-> o_hit && !a[23] && a[15:8] == 8'h80)
    else $error("bus interface select misplaced");

  AST_DISPLAY_ONLY: assert property (
    o_sel.display |-> o_hit && !a[23] && a[15:8] == 8'h83)
    else $error("display select misplaced");

  AST_MEMCTL_HIT: assert property (
    o_hit && !a[23] && a[15:8] == 8'h84 |-> o_sel.memctl)
    else $error("memory controller window missed");

  AST_POWER_ONLY: assert property (
    o_sel.power |-> o_hit && !a[23] &&
                    a[15:8] >= 8'h85 && a[15:8] <= 8'h8f)
    else $error("power select misplaced");

  AST_UNDEF_ONLY: assert property (
    o_ctrl_undef |-> o_hit && !a[23] && a[15:12] >= 4'h9)
    else $error("hole flagged inside a unit window");

  // other indices belong to other registers
  AST_IDX_OTHER_RD: assert property (
    i_ce && i_cfg_rd && i_cfg_index != 8'hb8
    |=> o_cfg_rdata == 8'h00)
    else $error("read at foreign index not zero");

  AST_IDX_OTHER_WR: assert property (
    i_ce && i_cfg_wr && i_cfg_index != 8'hb8 |=> $stable(cfg))
    else $error("write at foreign index changed config");

  AST_RSVD_ZERO: assert property (
    o_cfg_rdata[7:4] == 4'h0)
    else $error("reserved bits read back nonzero");

  COV_GFX: cover property (o_sel.gfx_mem);
  COV_SCRATCH: cover property (o_sel.scratch_pci);
  COV_POWER: cover property (o_sel.power);
  COV_UNDEF: cover property (o_ctrl_undef);
  COV_RECONFIG: cover property (
    i_ce && i_cfg_wr && i_cfg_index == 8'hb8 ##1 o_hit);

endmodule // isd_space_decoder

// >>> core/isd_pkg.sv
package isd_pkg;

  // ------------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------------
  localparam logic [7:0] ISD_CFG_INDEX = 8'hb8; // i/o config index
  localparam logic [7:0] ISD_CFG_RESET = 8'h00; // value after reset
  localparam int         ISD_BASE_LSB  = 0;     // region_base_sel [1:0]
  localparam int         ISD_SCR_LSB   = 2;     // scratch_size_sel [3:2]
  localparam int         ISD_RSVD_LSB  = 4;     // reserved [7:4]

  // region base select codes
  typedef enum logic [1:0] {
    ISD_BASE_OFF = 2'b00, // whole region disabled
    ISD_BASE_1G  = 2'b01, // base at 1 GB
    ISD_BASE_2G  = 2'b10, // base at 2 GB
    ISD_BASE_3G  = 2'b11  // base at 3 GB
  } isd_base_sel_t;

  localparam logic [31:0] ISD_BASE_ADDR_OFF = 32'h0000_0000;
  localparam logic [31:0] ISD_BASE_ADDR_1G  = 32'h4000_0000;
  localparam logic [31:0] ISD_BASE_ADDR_2G  = 32'h8000_0000;
  localparam logic [31:0] ISD_BASE_ADDR_3G  = 32'hc000_0000;

  // scratchpad sizes in kilobytes per code
  localparam logic [2:0] ISD_SCR_KB_0 = 3'h0;
  localparam logic [2:0] ISD_SCR_KB_1 = 3'h2;
  localparam logic [2:0] ISD_SCR_KB_2 = 3'h3;
  localparam logic [2:0] ISD_SCR_KB_3 = 3'h4;

  // ------------------------------------------------------------------
  // address layout
  // ------------------------------------------------------------------
  localparam int ISD_ADDR_GFX_BIT  = 23; // graphics memory vs control
  localparam int ISD_ADDR_CTRL_BIT = 15; // registers vs scratch/pci

  // control register units: bus if, pipeline, display, memctl, power
  localparam int ISD_UNITS = 5;
  localparam logic [15:0] ISD_UNIT_LO [ISD_UNITS] =
    '{16'h8000, 16'h8100, 16'h8300, 16'h8400, 16'h8500};
  localparam logic [15:0] ISD_UNIT_HI [ISD_UNITS] =
    '{16'h80ff, 16'h82ff, 16'h83ff, 16'h84ff, 16'h8fff};

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        valid; // request present this cycle
    logic        write; // write when high
    logic [31:0] addr;  // physical address
  } isd_req_t;

  typedef struct packed {
    logic [1:0]    scratch_size_sel;  // scratchpad size code
    isd_base_sel_t region_base_sel;   // region base code
  } isd_cfg_t;

  typedef struct packed {
    logic gfx_mem;     // graphics memory window
    logic power;       // power management registers
    logic memctl;      // memory controller
    logic display;     // display controller
    logic gpipe;       // graphics pipeline
    logic bus_if;      // internal bus interface unit
    logic scratch_pci; // scratchpad ram and pci access
  } isd_sel_t;

endpackage

// >>> core/isd_cfg_reg.sv
`timescale 1ns/10ps
module isd_cfg_reg
  import isd_pkg::*;
(
  input  wire logic       i_clk,       // core clock
  input  wire logic       i_sys_rst,   // sync reset, high
  input  wire logic       i_ce,        // clock enable
  input  wire logic       i_cfg_wr,    // config write strobe
  input  wire logic       i_cfg_rd,    // config read strobe
  input  wire logic [7:0] i_cfg_index, // config index
  input  wire logic [7:0] i_cfg_wdata, // config write data
  output logic      [7:0] o_cfg_rdata, // registered read data
  output isd_cfg_t        o_cfg,       // current configuration
  output logic      [2:0] o_scratch_kb // scratchpad size in kb
);

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  isd_cfg_t   cfg_q, cfg_d;     // stored low nibble
  logic [7:0] rdata_q, rdata_d; // read data holder

  // next values: write by i/o index, never through memory space
  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = rdata_q;
    if (i_cfg_wr && i_cfg_index == ISD_CFG_INDEX) begin
      // reserved upper nibble is dropped, so it reads back zero
      cfg_d = isd_cfg_t'(i_cfg_wdata[ISD_RSVD_LSB-1:0]);
    end
    if (i_cfg_rd) begin
      // other indices belong to other registers; answer zero
      rdata_d = (i_cfg_index == ISD_CFG_INDEX) ? {4'h0, cfg_q} : 8'h00;
    end
  end

  // registers only; clock enable freezes everything
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_q   <= isd_cfg_t'(ISD_CFG_RESET[ISD_RSVD_LSB-1:0]);
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // scratchpad size table
  always_comb begin
    unique case (cfg_q.scratch_size_sel)
      2'b00: o_scratch_kb = ISD_SCR_KB_0;
      2'b01: o_scratch_kb = ISD_SCR_KB_1;
      2'b10: o_scratch_kb = ISD_SCR_KB_2;
      2'b11: o_scratch_kb = ISD_SCR_KB_3;
    endcase
  end

  assign o_cfg       = cfg_q;
  assign o_cfg_rdata = rdata_q;

endmodule // isd_cfg_reg

// >>> core/isd_ctrl_decode.sv
`timescale 1ns/10ps
module isd_ctrl_decode
  import isd_pkg::*;
(
  input  wire logic                 i_en,       // register area access
  input  wire logic [15:0]          i_offset,   // offset in 64 kb space
  output logic      [ISD_UNITS-1:0] o_unit_sel, // one bit per unit
  output logic                      o_undef     // no unit claims it
);

  // ------------------------------------------------------------------
  // per-unit window compare
  // ------------------------------------------------------------------
  // windows do not overlap, so at most one bit can be set
  genvar g;
  generate
    for (g = 0; g < ISD_UNITS; g++) begin : g_unit
      assign o_unit_sel[g] = i_en &&
                             i_offset >= ISD_UNIT_LO[g] &&
                             i_offset <= ISD_UNIT_HI[g];
    end
  endgenerate

  // holes in the register area still complete, they just hit nothing
  assign o_undef = i_en && ~|o_unit_sel;

endmodule // isd_ctrl_decode

// >>> verification/isd_core_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// core-side requester: drives the internal bus request
// ------------------------------------------------------------------
module isd_core_model
  import isd_pkg::*;
(
  input  wire logic        i_clk,     // core clock
  input  wire logic        i_sys_rst, // sync reset, high
  input  wire logic        i_go,      // present a request
  input  wire logic        i_write,   // write when high
  input  wire logic [31:0] i_addr,    // wanted address
  input  wire logic        i_stray,   // junk in bits 22:16
  output isd_req_t         o_req      // request to the decoder
);
  logic [31:0] last_q; // last address put on the bus

  // remember the last address so an idle bus can show its inverse
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) last_q <= 32'h0000_0000;
    else if (i_go) last_q <= o_req.addr;
  end

  // released bus never repeats the old address, so a decoder that
  // ignores valid would be caught
  always_comb begin
    o_req.valid = i_go;
    o_req.write = i_write;
    if (!i_go) begin
      o_req.addr = ~last_q;
    end else if (!i_addr[23] && !i_stray) begin
      o_req.addr = {i_addr[31:23], 7'h00, i_addr[15:0]};
    end else if (!i_addr[23]) begin
      // stray bits only when a scenario asks, to prove they are ignored
      o_req.addr = {i_addr[31:23], 7'h55, i_addr[15:0]};
    end else begin
      o_req.addr = i_addr;
    end
  end
endmodule // isd_core_model

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import isd_pkg::*;
;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic        i_clk = 1'b0;          // core clock
  logic        i_sys_rst = 1'b1;      // sync reset
  logic        ce = 1'b1, wr = 1'b0;  // enable, write strobe
  logic        rd = 1'b0, go = 1'b0;  // read strobe, request
  logic        stray = 1'b0;          // junk in ignored bits
  logic [7:0]  idx = 8'h00, wd = 8'h00; // config index and data
  logic [31:0] addr = 32'h0000_0000;  // request address
  isd_req_t    req;                   // request from model
  isd_sel_t    sel;                   // unit select
  logic        hit, ack, undef;       // decode flags
  logic [7:0]  rdata;                 // config read data
  logic [2:0]  kb;                    // scratch size
  logic [31:0] base;                  // region base
  logic [7:0]  cfg_m = 8'h00;         // expected register
  logic        issue = 1'b0, rd_pend = 1'b0; // monitor flags
  logic [9:0]  nq[$];                 // expected decodes
  logic [7:0]  rq[$];                 // expected read data
  int          fail_count = 0, total_checks = 0, cycles = 0;
  integer      seed = 62239;          // fixed random seed
  logic [31:0] r;                     // random word
  logic [2:0]  kb_tab [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  logic [23:0] offs [16] = '{24'h00_0000, 24'h00_7fff, 24'h00_8000,
    24'h00_80ff, 24'h00_8100, 24'h00_82ff, 24'h00_8300, 24'h00_83ff,
    24'h00_8400, 24'h00_84ff, 24'h00_8500, 24'h00_8fff, 24'h00_9000,
    24'h00_ffff, 24'h80_0000, 24'hff_ffff};

  always #2 i_clk = ~i_clk;

  isd_core_model isd_core_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_go(go), .i_write(1'b0), .i_addr(addr), .i_stray(stray),
    .o_req(req));

  isd_space_decoder isd_space_decoder_i (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_ce(ce), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_index(idx), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
    .i_req(req), .o_sel(sel), .o_hit(hit), .o_ack(ack),
    .o_ctrl_undef(undef), .o_scratch_kb(kb),
    .o_region_base_address(base));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // expected {hit, ack, undef, select} worked out from the map
  function automatic logic [9:0] exp_dec(input logic v,
                                         input logic [31:0] a);
    logic h, ct, rg;
    logic [7:0] p;
    h  = v && cfg_m[1:0] != 2'b00 && a[31:30] == cfg_m[1:0] &&
         a[29:24] == 6'h00;
    ct = h && !a[23];
    rg = ct && a[15];
    p  = a[15:8];
    exp_dec = {h, h, rg && p >= 8'h90, h && a[23],
      rg && p >= 8'h85 && p <= 8'h8f, rg && p == 8'h84, rg && p == 8'h83,
      rg && (p == 8'h81 || p == 8'h82), rg && p == 8'h80, ct && !a[15]};
  endfunction

  // one config cycle; the read note carries the value before a write
  task automatic cfg(input logic c, w, rr, input logic [7:0] x, d);
    @(posedge i_clk);
    #1;
    {ce, wr, rd, idx, wd, go, issue} = {c, w, rr, x, d, 2'b00};
    if (c && rr) rq.push_back(x == 8'hb8 ? cfg_m : 8'h00);
    if (c && w && x == 8'hb8) cfg_m = {4'h0, d[3:0]};
  endtask

  // one request cycle through the core model
  task automatic req_c(input logic v, input logic [31:0] a, input logic s);
    @(posedge i_clk);
    #1;
    {wr, rd, go, addr, stray, issue} = {2'b00, v, a, s, 1'b1};
    nq.push_back(exp_dec(v, a));
  endtask

  task automatic idle;
    @(posedge i_clk);
    #1;
    {wr, rd, go, issue} = 4'h0;
  endtask

  // ------------------------------------------------------------------
  // monitor: pops the oldest note whenever a result is due
  // ------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (rd_pend) check(32'(rdata), 32'(rq.pop_front()));
    if (issue)
      check(32'({hit, ack, undef, sel}), 32'(nq.pop_front()));
    rd_pend = ce && rd && !i_sys_rst;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    cfg(1, 0, 1, 8'hb8, 8'h00);
    idle();
    check(base, 32'h0000_0000);
    // disabled region never decodes
    for (int c = 0; c < 4; c++)
      req_c(1, {2'(c), 30'h0000_8000}, 0);
    for (int c = 1; c < 4; c++) begin
      for (int s = 0; s < 4; s++) begin
        // reserved bits written high must read back low
        cfg(1, 1, 0, 8'hb8, {4'ha, 2'(s), 2'(c)});
        cfg(1, 0, 1, 8'hb8, 8'h00);
        idle();
        check(32'(kb), 32'(kb_tab[s]));
        check(base, {2'(c), 30'h0});
        for (int k = 0; k < 16; k++)
          req_c(1, {2'(c), 6'h00, offs[k]}, k[0]);
        req_c(1, {2'(c + 1), 6'h00, 24'h00_8000}, 0);
        req_c(1, {2'(c), 6'(1 << s), 24'h00_8000}, 0);
        req_c(0, {2'(c), 30'h0000_8100}, 0);
      end
    end
    // frame buffer line steps at both pixel depths
    for (int l = 0; l < 8; l++) begin
      req_c(1, {2'b11, 6'h00, 1'b1, 23'(l * 1024)}, 0);
      req_c(1, {2'b11, 6'h00, 1'b1, 23'(l * 2048)}, 0);
    end
    // random traffic with occasional reconfiguration
    for (int n = 0; n < 300; n++) begin
      r = $random(seed);
      if (n % 25 == 0) cfg(1, 1, 1, 8'hb8, r[7:0]);
      if (r[8]) r[29:24] = 6'h00;
      req_c(r[9], r, r[10]);
    end
    // refused writes and reads, then write and read together
    cfg(1, 1, 0, 8'hb9, 8'h07);
    cfg(1, 0, 1, 8'hb9, 8'h00);
    cfg(0, 1, 1, 8'hb8, 8'h06);
    cfg(1, 1, 1, 8'hb8, 8'h09);
    cfg(1, 0, 1, 8'hb8, 8'h00);
    // reset in mid-run returns the register to zero
    @(posedge i_clk);
    #1 i_sys_rst = 1'b1;
    cfg_m = 8'h00;
    idle();
    #0 i_sys_rst = 1'b0;
    cfg(1, 0, 1, 8'hb8, 8'h00);
    idle();
    idle();
    check(base, 32'h0000_0000);
    wrap_up();
  end
endmodule // tb_top
